/* File: core/timer_consts.svh */
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_TIMER_CONTROL 8'h88
`define IDX_TIMER_MODE_SELECT 8'h89
`define IDX_TIMER_A_LOW_BYTE 8'h8a
`define IDX_TIMER_B_LOW_BYTE 8'h8b
`define IDX_TIMER_A_HIGH_BYTE 8'h8c
`define IDX_TIMER_B_HIGH_BYTE 8'h8d
`define IDX_IRQ_STATUS 8'h90
`define IDX_IRQ_MASK 8'h91

// timer_control bit positions
`define TC_B_FLAG 7
`define TC_B_RUN 6
`define TC_A_FLAG 5
`define TC_A_RUN 4

// timer_mode_select bit positions (mode field low bit, count select, gate)
`define TM_A_MODE 0
`define TM_A_CT 2
`define TM_A_GATE 3
`define TM_B_MODE 4
`define TM_B_CT 6
`define TM_B_GATE 7

// irq status / mask bit positions
`define IRQ_A_BIT 0
`define IRQ_B_BIT 1

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// processor clocks per machine cycle
`define MACHINE_CYCLE_CLKS 12

`endif

/* File: core/timer_pkg.sv */
package timer_pkg;

	// two-bit mode field, in field-value order
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_8BIT_RELOAD,
		MODE_SPLIT
	} timer_mode_e;

	typedef logic [7:0] byte_t;

endpackage : timer_pkg

/* File: core/machine_cycle_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

module machine_cycle_prescaler #(
	parameter int DIVIDE = `MACHINE_CYCLE_CLKS
) (
	input wire logic i_core_clk, // processor clock
	input wire logic i_rst_n, // sync reset, active low
	output logic o_tick // one pulse per machine cycle
);

	logic [7:0] count_reg;

	// free-running divider; tick on the last clock of each machine cycle
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			count_reg <= `RST_BYTE;
			o_tick <= 1'b0;
		end
		else if (count_reg == 8'(DIVIDE - 1))
		begin
			count_reg <= `RST_BYTE;
			o_tick <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + 8'h01;
			o_tick <= 1'b0;
		end
	end

endmodule : machine_cycle_prescaler

`default_nettype wire

/* File: core/event_sampler.sv */
`timescale 1ns/1ps
`default_nettype none

module event_sampler (
	input wire logic i_core_clk, // processor clock
	input wire logic i_rst_n, // sync reset, active low
	input wire logic i_tick, // machine cycle tick
	input wire logic i_level, // external event input
	output logic o_fall // one-cycle pulse per falling edge
);

	logic now_reg;

	// sample once per machine cycle; a 1 then a 0 sample needs two cycles,
	// which caps the count rate; a glitch shorter than a cycle is still counted if a tick samples it
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			now_reg <= 1'b1;
			o_fall <= 1'b0;
		end
		else
		begin
			o_fall <= i_tick & now_reg & ~i_level;
			if (i_tick)
				now_reg <= i_level;
		end
	end

endmodule : event_sampler

`default_nettype wire

/* File: core/dual_timer_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

module dual_timer_counter
	import timer_pkg::*;
#(
	parameter int PRESCALE = `MACHINE_CYCLE_CLKS
) (
	input wire logic i_core_clk, // processor clock, 200 MHz
	input wire logic i_rst_n, // sync reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [11:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic o_pready, // apb ready
	output logic [31:0] o_prdata, // apb read data
	output logic o_pslverr, // apb error, unmapped address
	input wire logic i_timer_a_event_input, // event input of timer a
	input wire logic i_timer_b_event_input, // event input of timer b
	input wire logic i_timer_a_gate, // gate level of timer a
	input wire logic i_timer_b_gate, // gate level of timer b
	input wire logic i_timer_a_ack, // interrupt taken, clears flag a
	input wire logic i_timer_b_ack, // interrupt taken, clears flag b
	output logic o_irq // level interrupt
);

	byte_t timer_control_reg;
	byte_t timer_mode_select_reg;
	byte_t timer_a_low_byte_reg;
	byte_t timer_a_high_byte_reg;
	byte_t timer_b_low_byte_reg;
	byte_t timer_b_high_byte_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic tick;
	logic fall_a;
	logic fall_b;
	timer_mode_e mode_a;
	timer_mode_e mode_b;
	logic inc_a;
	logic inc_b;
	logic inc_a_high;
	logic [16:0] step_a;
	logic [16:0] step_b;
	logic [16:0] step_a_high;
	logic ovf_a;
	logic ovf_b;
	logic bus_done;
	logic wr_en;
	logic rd_en;
	logic [7:0] idx;
	logic mapped;
	logic [7:0] rd_byte;

	// register index from byte address; upper bits must be zero
	function automatic logic [7:0] addr_index(input logic [11:0] a);
		return a[9:2];
	endfunction : addr_index

	// one count step of a byte pair; bit 16 is the overflow
	function automatic logic [16:0] step(input timer_mode_e m, input byte_t lo,
		input byte_t hi, input logic inc);
		logic [16:0] r;
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0] c8;
		r = {1'b0, hi, lo};
		c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8 = {1'b0, lo} + 9'h001;
		if (inc)
		begin
			case (m)
				MODE_13BIT: r = {c13[13], c13[12:5], 3'h0, c13[4:0]};
				MODE_16BIT: r = c16;
				MODE_8BIT_RELOAD: r = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
				MODE_SPLIT: r = {c8[8], hi, c8[7:0]};
				default: r = {1'b0, hi, lo};
			endcase
		end
		// 13-bit mode keeps the three upper low-byte bits at zero
		if (m == MODE_13BIT)
			r[7:5] = 3'h0;
		return r;
	endfunction : step

	machine_cycle_prescaler #(
		.DIVIDE(PRESCALE)
	) u_prescaler (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.o_tick(tick)
	);

	event_sampler u_sample_a (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_level(i_timer_a_event_input),
		.o_fall(fall_a)
	);

	event_sampler u_sample_b (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_level(i_timer_b_event_input),
		.o_fall(fall_b)
	);

	// mode fields and count enables; no check of illegal combinations,
	// software must avoid first-timer reload without second-timer reload
	always_comb
	begin
		mode_a = timer_mode_e'(timer_mode_select_reg[`TM_A_MODE +: 2]);
		mode_b = timer_mode_e'(timer_mode_select_reg[`TM_B_MODE +: 2]);
		inc_a = timer_control_reg[`TC_A_RUN]
			& (~timer_mode_select_reg[`TM_A_GATE] | i_timer_a_gate)
			& (timer_mode_select_reg[`TM_A_CT] ? fall_a : tick);
		inc_b = timer_control_reg[`TC_B_RUN]
			& (~timer_mode_select_reg[`TM_B_GATE] | i_timer_b_gate)
			& (timer_mode_select_reg[`TM_B_CT] ? fall_b : tick)
			& (mode_b != MODE_SPLIT);
		// split high half counts machine cycles under the second run bit
		inc_a_high = (mode_a == MODE_SPLIT) & timer_control_reg[`TC_B_RUN] & tick;
	end

	// next values and overflow events
	always_comb
	begin
		step_a = step(mode_a, timer_a_low_byte_reg, timer_a_high_byte_reg, inc_a);
		step_b = step(mode_b, timer_b_low_byte_reg, timer_b_high_byte_reg, inc_b);
		step_a_high = step(MODE_SPLIT, timer_a_high_byte_reg, `RST_BYTE, inc_a_high);
		ovf_a = step_a[16];
		// in split mode the second flag belongs to the high half of timer a
		ovf_b = (mode_a == MODE_SPLIT) ? step_a_high[16] : step_b[16];
	end

	// bus decode; a transfer completes on the edge where ready is seen
	always_comb
	begin
		bus_done = i_psel & i_penable & o_pready;
		wr_en = bus_done & i_pwrite;
		rd_en = bus_done & ~i_pwrite;
		idx = addr_index(i_paddr);
		mapped = (i_paddr[11:10] == 2'h0);
		case (idx)
			`IDX_TIMER_CONTROL: rd_byte = timer_control_reg;
			`IDX_TIMER_MODE_SELECT: rd_byte = timer_mode_select_reg;
			`IDX_TIMER_A_LOW_BYTE: rd_byte = timer_a_low_byte_reg;
			`IDX_TIMER_B_LOW_BYTE: rd_byte = timer_b_low_byte_reg;
			`IDX_TIMER_A_HIGH_BYTE: rd_byte = timer_a_high_byte_reg;
			`IDX_TIMER_B_HIGH_BYTE: rd_byte = timer_b_high_byte_reg;
			`IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_reg};
			`IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
			default:
			begin
				rd_byte = `RST_BYTE;
				mapped = 1'b0;
			end
		endcase
	end

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			o_pready <= 1'b0;
			o_prdata <= `RST_WORD;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready <= i_psel & i_penable & ~o_pready;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
			if (i_psel & i_penable & ~o_pready & ~i_pwrite)
				o_prdata <= {24'h000000, rd_byte};
		end
	end

	// run bits and overflow flags; a hardware set wins over any clear
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			timer_control_reg <= `RST_BYTE;
		else
		begin
			if (wr_en && mapped && idx == `IDX_TIMER_CONTROL)
			begin
				timer_control_reg[`TC_B_RUN] <= i_pwdata[`TC_B_RUN];
				timer_control_reg[`TC_A_RUN] <= i_pwdata[`TC_A_RUN];
			end
			if (ovf_a)
				timer_control_reg[`TC_A_FLAG] <= 1'b1;
			else if (i_timer_a_ack || (wr_en && mapped && idx == `IDX_TIMER_CONTROL))
				timer_control_reg[`TC_A_FLAG] <= ~i_timer_a_ack & i_pwdata[`TC_A_FLAG];
			if (ovf_b)
				timer_control_reg[`TC_B_FLAG] <= 1'b1;
			else if (i_timer_b_ack || (wr_en && mapped && idx == `IDX_TIMER_CONTROL))
				timer_control_reg[`TC_B_FLAG] <= ~i_timer_b_ack & i_pwdata[`TC_B_FLAG];
		end
	end

	// mode select register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			timer_mode_select_reg <= `RST_BYTE;
		else if (wr_en && mapped && idx == `IDX_TIMER_MODE_SELECT)
			timer_mode_select_reg <= i_pwdata[7:0];
	end

	// timer a bytes; a software write beats a count in the same cycle
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			timer_a_low_byte_reg <= `RST_BYTE;
			timer_a_high_byte_reg <= `RST_BYTE;
		end
		else
		begin
			if (wr_en && mapped && idx == `IDX_TIMER_A_LOW_BYTE)
				timer_a_low_byte_reg <= i_pwdata[7:0];
			else
				timer_a_low_byte_reg <= step_a[7:0];
			if (wr_en && mapped && idx == `IDX_TIMER_A_HIGH_BYTE)
				timer_a_high_byte_reg <= i_pwdata[7:0];
			else if (mode_a == MODE_SPLIT)
				timer_a_high_byte_reg <= step_a_high[7:0];
			else
				timer_a_high_byte_reg <= step_a[15:8];
		end
	end

	// timer b bytes
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			timer_b_low_byte_reg <= `RST_BYTE;
			timer_b_high_byte_reg <= `RST_BYTE;
		end
		else
		begin
			if (wr_en && mapped && idx == `IDX_TIMER_B_LOW_BYTE)
				timer_b_low_byte_reg <= i_pwdata[7:0];
			else
				timer_b_low_byte_reg <= step_b[7:0];
			if (wr_en && mapped && idx == `IDX_TIMER_B_HIGH_BYTE)
				timer_b_high_byte_reg <= i_pwdata[7:0];
			else
				timer_b_high_byte_reg <= step_b[15:8];
		end
	end

	// sticky interrupt status, cleared by read; a new overflow wins
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			irq_status_reg <= 2'h0;
		else
		begin
			if (ovf_a)
				irq_status_reg[`IRQ_A_BIT] <= 1'b1;
			else if (rd_en && mapped && idx == `IDX_IRQ_STATUS)
				irq_status_reg[`IRQ_A_BIT] <= 1'b0;
			if (ovf_b)
				irq_status_reg[`IRQ_B_BIT] <= 1'b1;
			else if (rd_en && mapped && idx == `IDX_IRQ_STATUS)
				irq_status_reg[`IRQ_B_BIT] <= 1'b0;
		end
	end

	// mask register, one enables the source
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			irq_mask_reg <= 2'h0;
		else if (wr_en && mapped && idx == `IDX_IRQ_MASK)
			irq_mask_reg <= i_pwdata[1:0];
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_status_reg & irq_mask_reg);
	end

endmodule : dual_timer_counter

`default_nettype wire

/* File: dv/timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_monitor (
	input wire logic i_core_clk, // clock
	input wire logic i_rst_n, // sync reset
	input wire logic i_psel, // select
	input wire logic i_penable, // enable
	input wire logic i_pwrite, // direction
	input wire logic [11:0] i_paddr, // byte address
	input wire logic [31:0] i_pwdata, // write data
	input wire logic o_pready, // ready
	input wire logic [31:0] o_prdata, // read data
	input wire logic o_pslverr, // error
	input wire logic o_irq // interrupt
);
	logic hit;

	// own decode of the map, so a wrong decode in the design shows
	assign hit = i_paddr[11:10] == 2'h0 && i_paddr[9:2] inside {[8'h88:8'h8d], 8'h90, 8'h91};

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	ready_timing_a: assert property ((i_psel && !i_penable) ##1 (i_psel && i_penable)
		|-> !o_pready ##1 o_pready) else $error("ready not in second access cycle");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	ready_access_a: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access phase");
	upper_zero_a: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	mapped_ok_a: assert property (o_pready && hit |-> !o_pslverr)
		else $error("error on mapped register");
	unmapped_err_a: assert property (o_pready && !hit
		|-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
		else $error("unmapped access not refused");
	reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_irq && !o_pready && !o_pslverr)
		else $error("outputs active after reset");
	mask_off_a: assert property (o_pready && i_pwrite && hit && i_paddr[9:2] == 8'h91
		&& i_pwdata[1:0] == 2'h0 |=> ##1 !o_irq) else $error("irq with all masked");
endmodule : timer_monitor

bind dual_timer_counter timer_monitor u_timer_monitor (.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .o_irq(o_irq));

`default_nettype wire

/* File: dv/event_source.sv */
`timescale 1ns/1ps
`default_nettype none

module event_source #(
	parameter int HOLD = 12
) (
	input wire logic i_core_clk, // clock
	output logic o_timer_a_event_input, // level to timer a
	output logic o_timer_b_event_input // level to timer b
);
	logic [1:0] lvl = 2'b11;

	// idle high, so each pulse is one falling edge
	assign o_timer_a_event_input = lvl[0];
	assign o_timer_b_event_input = lvl[1];

	// each level stands just one machine cycle, the tightest legal source
	task automatic pulses(input int ch, input int n);
		repeat (2 * n)
		begin
			lvl[ch] <= ~lvl[ch];
			repeat (HOLD) @(posedge i_core_clk);
		end
	endtask : pulses
endmodule : event_source

`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

module testbench
	import timer_pkg::*;
;
	localparam int PS = `MACHINE_CYCLE_CLKS;
	localparam byte_t CTL = `IDX_TIMER_CONTROL;
	localparam byte_t MOD = `IDX_TIMER_MODE_SELECT;
	localparam byte_t AL = `IDX_TIMER_A_LOW_BYTE;
	localparam byte_t BL = `IDX_TIMER_B_LOW_BYTE;
	localparam byte_t AH = `IDX_TIMER_A_HIGH_BYTE;
	localparam byte_t BH = `IDX_TIMER_B_HIGH_BYTE;
	localparam byte_t STS = `IDX_IRQ_STATUS;
	localparam byte_t MSK = `IDX_IRQ_MASK;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic ack_a = 1'b0;
	logic ack_b = 1'b0;
	logic gate_a = 1'b1;
	logic ready, err, irq, ev_a, ev_b, slverr;
	logic [31:0] prdata, rd;
	int n_errors = 0;
	int checks_done = 0;

	// 200 MHz core clock
	always #2.5 clk = ~clk;

	// gate b held high; gate a is driven by the gating scenario
	dual_timer_counter #(.PRESCALE(PS)) u_dual_timer_counter (.i_core_clk(clk),
		.i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(ready), .o_prdata(prdata), .o_pslverr(err),
		.i_timer_a_event_input(ev_a), .i_timer_b_event_input(ev_b), .i_timer_a_gate(gate_a),
		.i_timer_b_gate(1'b1), .i_timer_a_ack(ack_a), .i_timer_b_ack(ack_b), .o_irq(irq));

	event_source #(.HOLD(PS)) u_event_source (.i_core_clk(clk),
		.o_timer_a_event_input(ev_a), .o_timer_b_event_input(ev_b));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one transfer; waits on ready, counts wait edges, idles a cycle after
	task automatic apb(input logic w, input byte_t idx, input byte_t wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (ready !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		check(n, 32'h1);
		rd = prdata;
		slverr = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input byte_t idx, input byte_t d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rc(input byte_t idx, input byte_t exp);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask : rc

	task automatic t_reset();
		rc(CTL, 8'h00);
		rc(MOD, 8'h00);
		rc(AL, 8'h00);
		rc(BH, 8'h00);
		rc(MSK, 8'h00);
		apb(1'b0, 8'h80, 8'h00);
		check(slverr, 32'h1);
		check(rd, 32'h0);
		$display("reset test done");
	endtask : t_reset

	task automatic t_count16();
		wr(MOD, 8'h05);
		wr(AH, 8'hff);
		wr(AL, 8'hfd);
		wr(MSK, 8'h01);
		wr(CTL, 8'h10);
		u_event_source.pulses(0, 3);
		repeat (2 * PS) @(posedge clk);
		rc(AL, 8'h00);
		rc(AH, 8'h00);
		rc(CTL, 8'h30);
		check(irq, 32'h1);
		rc(STS, 8'h01);
		rc(STS, 8'h00);
		check(irq, 32'h0);
		ack_a <= 1'b1;
		@(posedge clk);
		ack_a <= 1'b0;
		@(posedge clk);
		rc(CTL, 8'h10);
		wr(CTL, 8'h00);
		$display("count16 test done");
	endtask : t_count16

	task automatic t_mode13();
		wr(MOD, 8'h40);
		wr(BH, 8'hff);
		wr(BL, 8'hff);
		rc(BL, 8'h1f);
		wr(CTL, 8'h40);
		u_event_source.pulses(1, 1);
		repeat (2 * PS) @(posedge clk);
		rc(BL, 8'h00);
		rc(BH, 8'h00);
		rc(CTL, 8'hc0);
		check(irq, 32'h0);
		wr(MSK, 8'h03);
		@(posedge clk);
		check(irq, 32'h1);
		rc(STS, 8'h02);
		wr(MSK, 8'h00);
		wr(CTL, 8'h00);
		rc(CTL, 8'h00);
		$display("mode13 test done");
	endtask : t_mode13

	task automatic t_reload();
		wr(MOD, 8'h26);
		wr(AH, 8'h80);
		wr(AL, 8'hfe);
		wr(CTL, 8'h10);
		u_event_source.pulses(0, 2);
		repeat (2 * PS) @(posedge clk);
		rc(AL, 8'h80);
		rc(AH, 8'h80);
		rc(CTL, 8'h30);
		u_event_source.pulses(0, 1);
		repeat (2 * PS) @(posedge clk);
		rc(AL, 8'h81);
		wr(CTL, 8'h00);
		$display("reload test done");
	endtask : t_reload

	task automatic t_split();
		wr(MOD, 8'h77);
		wr(AL, 8'hff);
		wr(AH, 8'hfe);
		wr(BL, 8'h12);
		wr(CTL, 8'h10);
		repeat (4 * PS) @(posedge clk);
		rc(AH, 8'hfe);
		rc(AL, 8'hff);
		u_event_source.pulses(0, 1);
		repeat (2 * PS) @(posedge clk);
		rc(AL, 8'h00);
		rc(CTL, 8'h30);
		wr(CTL, 8'h40);
		u_event_source.pulses(1, 2);
		repeat (PS) @(posedge clk);
		rc(BL, 8'h12);
		rc(CTL, 8'hc0);
		wr(CTL, 8'h00);
		$display("split test done");
	endtask : t_split

	// gate bit set: no count while the gate input is low
	task automatic t_gate();
		wr(MOD, 8'h09);
		wr(AL, 8'h00);
		wr(AH, 8'h00);
		gate_a <= 1'b0;
		wr(CTL, 8'h10);
		repeat (4 * PS) @(posedge clk);
		rc(AL, 8'h00);
		gate_a <= 1'b1;
		repeat (4 * PS) @(posedge clk);
		wr(CTL, 8'h00);
		apb(1'b0, AL, 8'h00);
		check({31'h0, rd[7:0] >= 8'h04 && rd[7:0] <= 8'h05}, 32'h1);
		$display("gate test done");
	endtask : t_gate

	// run window is 1204 clocks, so 100 or 101 machine cycles by phase
	task automatic t_rate();
		wr(MOD, 8'h01);
		wr(AL, 8'h00);
		wr(AH, 8'h00);
		wr(CTL, 8'h10);
		repeat (100 * PS) @(posedge clk);
		wr(CTL, 8'h00);
		apb(1'b0, AL, 8'h00);
		check({31'h0, rd[7:0] >= 8'h64 && rd[7:0] <= 8'h65}, 32'h1);
		$display("rate test done");
	endtask : t_rate

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// reset for 8 cycles, then the scenarios in turn
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_count16();
		t_mode13();
		t_reload();
		t_split();
		t_gate();
		t_rate();
		tally_and_finish();
	end

	// scenarios need about 2000 cycles; fifteen times that means a hang
	initial
	begin
		#150000;
		n_errors++;
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
